// File: src/phyat_tuning_regs.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "phyat_consts.svh"

module phyat_tuning_regs #(
   parameter logic [15:0] LOWPASS_RST = 16'h0000,
   parameter logic [9:0] FFE_RST = 10'h000
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] trim_gain_c,
   input wire logic [3:0] trim_gain_d,
   input wire logic transmit_test_clock,
   input wire logic normal_clock,
   output logic clock_out,
   output logic clock_out_select,
   output logic [3:0] tx_fine_gain_c,
   output logic [3:0] tx_fine_gain_d,
   output logic [4:0] swing_value_a,
   output logic [4:0] swing_value_b,
   output logic [4:0] swing_value_c,
   output logic [4:0] swing_value_d,
   output logic swing_override_a,
   output logic swing_override_b,
   output logic swing_override_c,
   output logic swing_override_d,
   output logic [15:0] rx_lowpass_setting,
   output logic [15:0] rx_equalizer_enables,
   output logic [15:0] sync_buffer_setting,
   output logic [15:0] loopback_setting,
   output logic [15:0] signal_processor_setting,
   output logic [9:0] feedforward_setting
);

   phyat_pkg::phyat_state_t state_q;
   phyat_pkg::phyat_state_t state_d;

   logic [9:0] word_idx;
   logic mapped;
   logic ready;
   logic do_write;
   logic [31:0] read_word;

   // Word index from the byte address; low two bits ignored
   assign word_idx = paddr[11:2];
   assign ready = (state_q.init_cnt == `PHYAT_READY_CNT);

   always_comb begin
      mapped = 1'b1;
      read_word = 32'h0000_0000;
      case (word_idx)
         `PHYAT_IDX_GAIN_CD: begin
            read_word[`PHYAT_HI_MSB:`PHYAT_HI_LSB] = state_q.gain_d;
            read_word[`PHYAT_LO_MSB:`PHYAT_LO_LSB] = state_q.gain_c;
         end
         `PHYAT_IDX_SWING_AB: begin
            read_word[`PHYAT_FORCE_HI] = state_q.swing_b.force_on;
            read_word[`PHYAT_SW_HI_MSB:`PHYAT_HI_LSB] = state_q.swing_b.value;
            read_word[`PHYAT_FORCE_LO] = state_q.swing_a.force_on;
            read_word[`PHYAT_SW_LO_MSB:`PHYAT_LO_LSB] = state_q.swing_a.value;
         end
         `PHYAT_IDX_SWING_CD: begin
            read_word[`PHYAT_FORCE_HI] = state_q.swing_d.force_on;
            read_word[`PHYAT_SW_HI_MSB:`PHYAT_HI_LSB] = state_q.swing_d.value;
            read_word[`PHYAT_FORCE_LO] = state_q.swing_c.force_on;
            read_word[`PHYAT_SW_LO_MSB:`PHYAT_LO_LSB] = state_q.swing_c.value;
         end
         `PHYAT_IDX_LOWPASS: begin
            read_word[15:0] = state_q.lowpass;
         end
         `PHYAT_IDX_EQ_EN: begin
            read_word[15:0] = state_q.eq_en;
         end
         `PHYAT_IDX_CLK_OUT: begin
            read_word[`PHYAT_CLK_SEL_BIT] = state_q.clk_sel;
         end
         `PHYAT_IDX_SYNC_BUF: begin
            read_word[15:0] = state_q.sync_buf;
         end
         `PHYAT_IDX_LOOPBACK: begin
            read_word[15:0] = state_q.loopback;
         end
         `PHYAT_IDX_DSP_CFG: begin
            read_word[15:0] = state_q.dsp_cfg;
         end
         `PHYAT_IDX_FFE_CFG: begin
            read_word[15:10] = `PHYAT_FFE_FIXED;
            read_word[`PHYAT_FFE_MSB:0] = state_q.ffe;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   assign do_write = psel && penable && pwrite && ready && mapped;

   always_comb begin
      state_d = state_q;
      // Fuse trim pins are static but asynchronous to the core clock
      state_d.trim_c_meta = trim_gain_c;
      state_d.trim_c_sync = state_q.trim_c_meta;
      state_d.trim_d_meta = trim_gain_d;
      state_d.trim_d_sync = state_q.trim_d_meta;
      if (state_q.init_cnt != `PHYAT_READY_CNT) begin
         state_d.init_cnt = state_q.init_cnt + 3'h1;
      end
      // Trim captured once the synchroniser has filled
      if (state_q.init_cnt == `PHYAT_TRIM_LOAD_CNT) begin
         state_d.gain_c = state_q.trim_c_sync;
         state_d.gain_d = state_q.trim_d_sync;
      end
      // Read data registered while selected; stable in the access phase
      if (psel) begin
         state_d.prdata = read_word;
      end
      if (do_write) begin
         case (word_idx)
            `PHYAT_IDX_GAIN_CD: begin
               // Reserved nibbles are not stored
               state_d.gain_d = pwdata[`PHYAT_HI_MSB:`PHYAT_HI_LSB];
               state_d.gain_c = pwdata[`PHYAT_LO_MSB:`PHYAT_LO_LSB];
            end
            `PHYAT_IDX_SWING_AB: begin
               state_d.swing_b.force_on = pwdata[`PHYAT_FORCE_HI];
               state_d.swing_b.value = pwdata[`PHYAT_SW_HI_MSB:`PHYAT_HI_LSB];
               state_d.swing_a.force_on = pwdata[`PHYAT_FORCE_LO];
               state_d.swing_a.value = pwdata[`PHYAT_SW_LO_MSB:`PHYAT_LO_LSB];
            end
            `PHYAT_IDX_SWING_CD: begin
               state_d.swing_d.force_on = pwdata[`PHYAT_FORCE_HI];
               state_d.swing_d.value = pwdata[`PHYAT_SW_HI_MSB:`PHYAT_HI_LSB];
               state_d.swing_c.force_on = pwdata[`PHYAT_FORCE_LO];
               state_d.swing_c.value = pwdata[`PHYAT_SW_LO_MSB:`PHYAT_LO_LSB];
            end
            `PHYAT_IDX_LOWPASS: begin
               state_d.lowpass = pwdata[15:0];
            end
            `PHYAT_IDX_EQ_EN: begin
               state_d.eq_en = pwdata[15:0];
            end
            `PHYAT_IDX_CLK_OUT: begin
               state_d.clk_sel = pwdata[`PHYAT_CLK_SEL_BIT];
            end
            `PHYAT_IDX_SYNC_BUF: begin
               state_d.sync_buf = pwdata[15:0];
            end
            `PHYAT_IDX_LOOPBACK: begin
               // Takes any value; the soft reset afterwards is software's job
               state_d.loopback = pwdata[15:0];
            end
            `PHYAT_IDX_DSP_CFG: begin
               state_d.dsp_cfg = pwdata[15:0];
            end
            `PHYAT_IDX_FFE_CFG: begin
               state_d.ffe = pwdata[`PHYAT_FFE_MSB:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= '0;
         state_q.swing_a.value <= `PHYAT_SWING_RST;
         state_q.swing_b.value <= `PHYAT_SWING_RST;
         state_q.swing_c.value <= `PHYAT_SWING_RST;
         state_q.swing_d.value <= `PHYAT_SWING_RST;
         state_q.lowpass <= LOWPASS_RST;
         state_q.eq_en <= `PHYAT_EQ_EN_RST;
         state_q.clk_sel <= `PHYAT_CLK_SEL_RST;
         state_q.sync_buf <= `PHYAT_SYNC_BUF_RST;
         state_q.loopback <= `PHYAT_LOOPBACK_RST;
         state_q.dsp_cfg <= `PHYAT_DSP_CFG_RST;
         state_q.ffe <= FFE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // Bus holds the master in the access phase until init count reaches the ready count, two cycles after trim load
   assign pready = psel && penable && ready;
   assign pslverr = psel && penable && ready && !mapped;
   assign prdata = state_q.prdata;

   phyat_swing_drive u_swing_a (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .swing(state_q.swing_a),
      .drive_value(swing_value_a),
      .drive_force(swing_override_a)
   );

   phyat_swing_drive u_swing_b (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .swing(state_q.swing_b),
      .drive_value(swing_value_b),
      .drive_force(swing_override_b)
   );

   phyat_swing_drive u_swing_c (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .swing(state_q.swing_c),
      .drive_value(swing_value_c),
      .drive_force(swing_override_c)
   );

   phyat_swing_drive u_swing_d (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .swing(state_q.swing_d),
      .drive_value(swing_value_d),
      .drive_force(swing_override_d)
   );

   // Clock path mux for compliance testing; not a data output
   assign clock_out = state_q.clk_sel ? transmit_test_clock : normal_clock;
   assign clock_out_select = state_q.clk_sel;
   assign tx_fine_gain_c = state_q.gain_c;
   assign tx_fine_gain_d = state_q.gain_d;
   assign rx_lowpass_setting = state_q.lowpass;
   assign rx_equalizer_enables = state_q.eq_en;
   assign sync_buffer_setting = state_q.sync_buf;
   assign loopback_setting = state_q.loopback;
   assign signal_processor_setting = state_q.dsp_cfg;
   assign feedforward_setting = state_q.ffe;

endmodule

`default_nettype wire

// File: src/phyat_consts.svh
// What this block does
// - Channel D fine transmit gain in bits 11:8, loaded from trim, read-write.
// - Channel C fine gain in bits 3:0; bits 15:12 and 7:4 read zero.
// - Gain code 0000 is -16%, 1000 unchanged, 1111 +14%, 2% steps.
// - Channel B swing bits 12:8 drive the line only while force bit 13 set.
// - Channel A swing bits 4:0, reset 10000, applied only while bit 5 set.
// - Channels D and C swing in 12:8 and 4:0, reset 10000, forced by 13 and 5.
// - Receiver equalizer enable register resets to 0x0000 and is read-write.
// - Clock select bit 4 routes the transmit test clock to clock out; resets 0.
// - Clock-out register bits 15:5 and 3:0 ignore writes and read zero.
// - Signal processor configuration resets to 0x051C, read-write; 0x1027 allowed.
// - Sync buffer control is 16-bit read-write, reset 0x9F22, opaque.
`ifndef PHYAT_CONSTS_SVH
`define PHYAT_CONSTS_SVH

// Register indices; byte address is four times the index
`define PHYAT_IDX_GAIN_CD 10'h0A1
`define PHYAT_IDX_SWING_AB 10'h0A2
`define PHYAT_IDX_SWING_CD 10'h0A3
`define PHYAT_IDX_LOWPASS 10'h0B3
`define PHYAT_IDX_EQ_EN 10'h0C0
`define PHYAT_IDX_CLK_OUT 10'h0C6
`define PHYAT_IDX_SYNC_BUF 10'h0E9
`define PHYAT_IDX_LOOPBACK 10'h0FE
`define PHYAT_IDX_DSP_CFG 10'h100
`define PHYAT_IDX_FFE_CFG 10'h12C

// Field positions
`define PHYAT_HI_MSB 11
`define PHYAT_HI_LSB 8
`define PHYAT_LO_MSB 3
`define PHYAT_LO_LSB 0
`define PHYAT_SW_HI_MSB 12
`define PHYAT_SW_LO_MSB 4
`define PHYAT_FORCE_HI 13
`define PHYAT_FORCE_LO 5
`define PHYAT_CLK_SEL_BIT 4
`define PHYAT_FFE_MSB 9

// Reset values
`define PHYAT_SWING_RST 5'h10
`define PHYAT_EQ_EN_RST 16'h0000
`define PHYAT_CLK_SEL_RST 1'h0
`define PHYAT_SYNC_BUF_RST 16'h9F22
`define PHYAT_LOOPBACK_RST 16'h0001
`define PHYAT_DSP_CFG_RST 16'h051C
`define PHYAT_FFE_FIXED 6'h03

// Cycles after reset release before trim is loaded and the bus answers
`define PHYAT_TRIM_LOAD_CNT 3'h2
`define PHYAT_READY_CNT 3'h4

`endif

// File: src/phyat_pkg.sv
`default_nettype none
package phyat_pkg;

   typedef struct packed {
      logic [4:0] value;
      logic force_on;
   } phyat_swing_t;

   typedef struct packed {
      logic [2:0] init_cnt;
      logic [3:0] trim_c_meta;
      logic [3:0] trim_c_sync;
      logic [3:0] trim_d_meta;
      logic [3:0] trim_d_sync;
      logic [3:0] gain_c;
      logic [3:0] gain_d;
      phyat_swing_t swing_a;
      phyat_swing_t swing_b;
      phyat_swing_t swing_c;
      phyat_swing_t swing_d;
      logic [15:0] lowpass;
      logic [15:0] eq_en;
      logic clk_sel;
      logic [15:0] sync_buf;
      logic [15:0] loopback;
      logic [15:0] dsp_cfg;
      logic [9:0] ffe;
      logic [31:0] prdata;
   } phyat_state_t;

   typedef struct packed {
      logic [4:0] applied;
      logic enable;
   } phyat_drv_t;

endpackage

`default_nettype wire

// File: src/phyat_swing_drive.sv
`timescale 1ns/1ps
`default_nettype none
`include "phyat_consts.svh"

// Presents one channel's swing to the line driver only while forced
module phyat_swing_drive (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire phyat_pkg::phyat_swing_t swing,
   output logic [4:0] drive_value,
   output logic drive_force
);

   phyat_pkg::phyat_drv_t state_q;
   phyat_pkg::phyat_drv_t state_d;

   always_comb begin
      state_d = state_q;
      state_d.enable = swing.force_on;
      if (swing.force_on) begin
         state_d.applied = swing.value;
      end else begin
         state_d.applied = `PHYAT_SWING_RST;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= '{applied: `PHYAT_SWING_RST, enable: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign drive_value = state_q.applied;
   assign drive_force = state_q.enable;

endmodule

`default_nettype wire

// File: verif/phyat_tuning_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module phyat_tuning_regs_checker (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic transmit_test_clock,
   input wire logic normal_clock,
   input wire logic clock_out,
   input wire logic clock_out_select,
   input wire logic [3:0] tx_fine_gain_c,
   input wire logic [3:0] tx_fine_gain_d,
   input wire logic [4:0] swing_value_a,
   input wire logic [4:0] swing_value_b,
   input wire logic [4:0] swing_value_c,
   input wire logic [4:0] swing_value_d,
   input wire logic swing_override_a,
   input wire logic swing_override_b,
   input wire logic swing_override_c,
   input wire logic swing_override_d,
   input wire logic [15:0] sync_buffer_setting,
   input wire logic [15:0] signal_processor_setting,
   input wire logic [9:0] feedforward_setting
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Completed write to one byte address
   sequence s_wr(logic [11:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   a_gain_write: assert property (s_wr(12'h284) |=> tx_fine_gain_d == $past(pwdata[11:8])
      && tx_fine_gain_c == $past(pwdata[3:0])) else $error("gain write lost");
   a_swing_a_idle: assert property (!swing_override_a |-> swing_value_a == 5'h10)
      else $error("swing a applied unforced");
   a_swing_b_idle: assert property (!swing_override_b |-> swing_value_b == 5'h10)
      else $error("swing b applied unforced");
   a_swing_c_idle: assert property (!swing_override_c |-> swing_value_c == 5'h10)
      else $error("swing c applied unforced");
   a_swing_d_idle: assert property (!swing_override_d |-> swing_value_d == 5'h10)
      else $error("swing d applied unforced");
   a_clock_out_select_route: assert property (clock_out ==
      (clock_out_select ? transmit_test_clock : normal_clock)) else $error("clock out wrong");
   a_clk_sel_write: assert property (s_wr(12'h318) |=>
      clock_out_select == $past(pwdata[4])) else $error("clock select write lost");
   a_dsp_write: assert property (s_wr(12'h400) |=>
      signal_processor_setting == $past(pwdata[15:0])) else $error("dsp write lost");
   a_sync_write: assert property (s_wr(12'h3A4) |=>
      sync_buffer_setting == $past(pwdata[15:0])) else $error("sync write lost");
   a_ffe_write: assert property (s_wr(12'h4B0) |=>
      feedforward_setting == $past(pwdata[9:0])) else $error("ffe write lost");
   a_reset_values: assert property ($rose(reset_n) |-> signal_processor_setting == 16'h051C
      && sync_buffer_setting == 16'h9F22) else $error("reset value wrong");
endmodule
bind phyat_tuning_regs phyat_tuning_regs_checker i_phyat_tuning_regs_checker (
   .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .transmit_test_clock(transmit_test_clock),
   .normal_clock(normal_clock), .clock_out(clock_out), .clock_out_select(clock_out_select),
   .tx_fine_gain_c(tx_fine_gain_c), .tx_fine_gain_d(tx_fine_gain_d),
   .swing_value_a(swing_value_a), .swing_value_b(swing_value_b), .swing_value_c(swing_value_c),
   .swing_value_d(swing_value_d),
   .swing_override_a(swing_override_a), .swing_override_b(swing_override_b),
   .swing_override_c(swing_override_c), .swing_override_d(swing_override_d),
   .sync_buffer_setting(sync_buffer_setting),
   .signal_processor_setting(signal_processor_setting),
   .feedforward_setting(feedforward_setting));
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, ttc = 0, nck = 0, clock_out, sel;
   logic [3:0] gc, gd;
   logic [4:0] va, vb, vc, vd;
   logic oa, ob, oc, od;
   logic [15:0] lp, eq, sy, lb, dsp;
   logic [9:0] ffe;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   always #10 core_clk = ~core_clk;
   phyat_tuning_regs i_phyat_tuning_regs (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trim_gain_c(4'h5), .trim_gain_d(4'hA),
      .transmit_test_clock(ttc), .normal_clock(nck), .clock_out(clock_out),
      .clock_out_select(sel), .tx_fine_gain_c(gc), .tx_fine_gain_d(gd), .swing_value_a(va),
      .swing_value_b(vb), .swing_value_c(vc), .swing_value_d(vd), .swing_override_a(oa),
      .swing_override_b(ob), .swing_override_c(oc), .swing_override_d(od),
      .rx_lowpass_setting(lp), .rx_equalizer_enables(eq), .sync_buffer_setting(sy),
      .loopback_setting(lb), .signal_processor_setting(dsp), .feedforward_setting(ffe));
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr_rd(input logic [11:0] a, input logic [15:0] d, input logic [15:0] x);
      apb(1, a, d);
      apb(0, a, 16'h0000);
      `CHK(r, {16'h0000, x})
      `CHK(e, 1'b0)
   endtask
   task automatic t_reset();
      logic [11:0] a[10] = '{12'h284, 12'h288, 12'h28C, 12'h2CC, 12'h300, 12'h318, 12'h3A4,
         12'h3F8, 12'h400, 12'h4B0};
      logic [15:0] x[10] = '{16'h0A05, 16'h1010, 16'h1010, 16'h0000, 16'h0000, 16'h0000,
         16'h9F22, 16'h0001, 16'h051C, 16'h0C00};
      for (int i = 0; i < 10; i++) begin
         apb(0, a[i], 16'h0000);
         `CHK(r, {16'h0000, x[i]})
      end
      `CHK({gd, gc}, 8'hA5)
      $display("test reset done");
   endtask
   task automatic t_regs();
      wr_rd(12'h284, 16'hFFFF, 16'h0F0F);
      `CHK({gd, gc}, 8'hFF)
      wr_rd(12'h284, 16'h0008, 16'h0008);
      `CHK({gd, gc}, 8'h08)
      wr_rd(12'h288, 16'hFFFF, 16'h3F3F);
      wr_rd(12'h28C, 16'hFFFF, 16'h3F3F);
      `CHK({oa, ob, oc, od, va, vb, vc, vd}, 24'hFFFFFF)
      wr_rd(12'h288, 16'h1F0B, 16'h1F0B);
      wr_rd(12'h28C, 16'h2103, 16'h2103);
      `CHK({oa, ob, oc, od, va, vb, vc, vd}, 24'h184201)
      $display("test gain and swing done");
   endtask
   task automatic t_clk();
      ttc <= 1;
      wr_rd(12'h318, 16'hFFFF, 16'h0010);
      `CHK({sel, clock_out}, 2'b11)
      wr_rd(12'h318, 16'hFFEF, 16'h0000);
      `CHK({sel, clock_out}, 2'b00)
      $display("test clock out done");
   endtask
   task automatic t_rw();
      wr_rd(12'h2CC, 16'h000C, 16'h000C);
      wr_rd(12'h300, 16'hC3A5, 16'hC3A5);
      wr_rd(12'h3A4, 16'h5A5A, 16'h5A5A);
      wr_rd(12'h3F8, 16'h7390, 16'h7390);
      // Soft reset request goes to the control register, which lives outside this bank
      apb(1, 12'h07C, 16'h4000);
      `CHK({e, lb}, 17'h17390)
      wr_rd(12'h400, 16'h1027, 16'h1027);
      wr_rd(12'h4B0, 16'hFFFF, 16'h0FFF);
      wr_rd(12'h4B0, 16'h0E81, 16'h0E81);
      `CHK({lp, eq, sy, lb, dsp, ffe}, {80'h000CC3A55A5A73901027, 10'h281})
      apb(1, 12'h000, 16'hFFFF);
      `CHK(e, 1'b1)
      apb(0, 12'h000, 16'h0000);
      `CHK({e, r}, 33'h100000000)
      $display("test read write done");
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1;
      t_reset();
      t_regs();
      t_clk();
      t_rw();
      final_report();
   end
endmodule
`default_nettype wire
